// ---- common/clcc_pkg.sv ----
// Package with register map, field layout and types of the configurable logic cell.
package clcc_pkg;

  // Bus and source selector widths.
  localparam int CLCC_ADDR_W = 8;
  localparam int CLCC_DATA_W = 32;
  localparam int CLCC_SEL_W  = 6;

  // Register byte offsets.
  localparam logic [7:0] CLCC_OFF_CONTROL  = 8'h00;
  localparam logic [7:0] CLCC_OFF_POLARITY = 8'h04;
  localparam logic [7:0] CLCC_OFF_SRC_0    = 8'h08;
  localparam logic [7:0] CLCC_OFF_SRC_1    = 8'h0c;
  localparam logic [7:0] CLCC_OFF_SRC_2    = 8'h10;
  localparam logic [7:0] CLCC_OFF_SRC_3    = 8'h14;
  localparam logic [7:0] CLCC_OFF_GATE_0   = 8'h18;
  localparam logic [7:0] CLCC_OFF_GATE_1   = 8'h1c;
  localparam logic [7:0] CLCC_OFF_GATE_2   = 8'h20;
  localparam logic [7:0] CLCC_OFF_GATE_3   = 8'h24;
  localparam logic [7:0] CLCC_OFF_IRQ_STAT = 8'h28;
  localparam logic [7:0] CLCC_OFF_IRQ_MASK = 8'h2c;

  // Bit positions inside cell_control, polarity_control and the interrupt registers.
  localparam int CLCC_BIT_ENABLE   = 7;
  localparam int CLCC_BIT_OUT      = 5;
  localparam int CLCC_BIT_RISE     = 4;
  localparam int CLCC_BIT_FALL     = 3;
  localparam int CLCC_BIT_FINV     = 7;
  localparam int CLCC_BIT_IRQ_CELL = 0;

  // Values after reset.
  localparam logic [7:0] CLCC_RST_CONTROL = 8'h00;
  localparam logic       CLCC_RST_FINV    = 1'b0;
  localparam logic       CLCC_RST_MASK    = 1'b0;

  // Logic function codes.
  typedef enum logic [2:0] {
    CLCC_FN_AND_OR  = 3'h0,
    CLCC_FN_OR_XOR  = 3'h1,
    CLCC_FN_AND4    = 3'h2,
    CLCC_FN_SR      = 3'h3,
    CLCC_FN_DFF_SR  = 3'h4,
    CLCC_FN_DFF2_R  = 3'h5,
    CLCC_FN_JK_R    = 3'h6,
    CLCC_FN_LATCH   = 3'h7
  } clcc_func_t;

  // Writable fields of the control register.
  typedef struct packed {
    logic       cell_enable;
    logic       rise_irq_enable;
    logic       fall_irq_enable;
    clcc_func_t function_select;
  } clcc_ctrl_t;

endpackage

// ---- hdl/clcc_cell.sv ----
// Configurable logic cell with Wishbone register access and edge interrupt.
`timescale 1ns/100ps

module clcc_cell #(
  parameter int NUM_SRC = 64
) (
  // Clock and reset.
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  // Wishbone classic slave.
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [clcc_pkg::CLCC_ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [clcc_pkg::CLCC_DATA_W-1:0] wb_dat_i,
  output logic      [clcc_pkg::CLCC_DATA_W-1:0] wb_dat_o,
  output logic                               wb_ack_o,
  // Shared source signals and cell result.
  input  wire logic [NUM_SRC-1:0]            src_i,
  output logic                               cell_output_o,
  output logic                               irq_o
);
  import clcc_pkg::*;

  // Source selectors are six bits wide, so more sources cannot be reached.
  if (NUM_SRC < 1 || NUM_SRC > 64) begin : g_bad_num_src
    $error("NUM_SRC must lie between 1 and 64");
  end

  clcc_ctrl_t                ctrl;
  logic                      final_invert;
  logic [3:0]                gate_invert;
  logic [CLCC_SEL_W-1:0]     input_source [4];
  logic [7:0]                gate_select [4];
  logic                      cell_irq_flag;
  logic                      irq_mask;
  logic [NUM_SRC-1:0]        src_s1;
  logic [NUM_SRC-1:0]        src_s2;
  logic [NUM_SRC-1:0]        src_s3;
  logic [NUM_SRC-1:0]        src_filt;
  logic [3:0]                data_in;
  logic [3:0]                gate_out;
  logic                      seq_q;
  logic                      gate0_prev;
  logic                      func_result;
  logic                      cell_output;
  logic                      cell_output_prev;
  logic                      wr_en;
  logic                      rd_en;
  logic                      out_rise;
  logic                      out_fall;
  logic                      irq_event;
  logic [7:0]                next_rdata;

  // Bus access strobes; writes land only in the low byte lane.
  assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
  assign rd_en = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  // Each source bit passes three flops; the filtered value moves when stages two and three agree.
  for (genvar i = 0; i < NUM_SRC; i++) begin : g_sync
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        src_s1[i]   <= 1'b0;
        src_s2[i]   <= 1'b0;
        src_s3[i]   <= 1'b0;
        src_filt[i] <= 1'b0;
      end else begin
        src_s1[i] <= src_i[i];
        src_s2[i] <= src_s1[i];
        src_s3[i] <= src_s2[i];
        if (src_s2[i] == src_s3[i]) begin
          src_filt[i] <= src_s3[i];
        end
      end
    end
  end

  // Input selection and data gating, one slice per data input and gate.
  for (genvar k = 0; k < 4; k++) begin : g_gate
    // An out of range selector feeds a zero into the data input.
    assign data_in[k] = (32'(input_source[k]) < NUM_SRC) ?
                        src_filt[input_source[k]] : 1'b0;
    // The gate is an OR of the enabled true and inverted terms, then optionally inverted.
    assign gate_out[k] = gate_invert[k] ^ (|((gate_select[k] & {data_in[3], ~data_in[3],
                         data_in[2], ~data_in[2], data_in[1], ~data_in[1],
                         data_in[0], ~data_in[0]})));
  end

  // Control register: cleared by reset, output bit is not writable.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= clcc_ctrl_t'({CLCC_RST_CONTROL[CLCC_BIT_ENABLE], CLCC_RST_CONTROL[CLCC_BIT_RISE],
                            CLCC_RST_CONTROL[CLCC_BIT_FALL],
                            CLCC_RST_CONTROL[2:0]});
    end else if (wr_en && wb_adr_i == CLCC_OFF_CONTROL) begin
      ctrl.cell_enable     <= wb_dat_i[CLCC_BIT_ENABLE];
      ctrl.rise_irq_enable <= wb_dat_i[CLCC_BIT_RISE];
      ctrl.fall_irq_enable <= wb_dat_i[CLCC_BIT_FALL];
      ctrl.function_select <= clcc_func_t'(wb_dat_i[2:0]);
    end
  end

  // Final output inversion bit, cleared by reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      final_invert <= CLCC_RST_FINV;
    end else if (wr_en && wb_adr_i == CLCC_OFF_POLARITY) begin
      final_invert <= wb_dat_i[CLCC_BIT_FINV];
    end
  end

  // Gate inversions, sources and gate selects survive reset and power up unknown.
  always_ff @(posedge clk_i) begin
    if (wr_en && wb_adr_i == CLCC_OFF_POLARITY) begin
      gate_invert <= wb_dat_i[3:0];
    end
    for (int k = 0; k < 4; k++) begin
      if (wr_en && wb_adr_i == CLCC_OFF_SRC_0 + 8'(4 * k)) begin
        input_source[k] <= wb_dat_i[CLCC_SEL_W-1:0];
      end
      if (wr_en && wb_adr_i == CLCC_OFF_GATE_0 + 8'(4 * k)) begin
        gate_select[k] <= wb_dat_i[7:0];
      end
    end
  end

  // Previous gate 0 level, used as the clock of the flip-flop functions.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gate0_prev <= 1'b0;
    end else begin
      gate0_prev <= gate_out[0];
    end
  end

  // Storage of the latch and flip-flop functions; reset inputs win over set inputs except in the SR function, where set wins.
  always_ff @(posedge clk_i) begin
    if (rst_i || !ctrl.cell_enable) begin
      seq_q <= 1'b0;
    end else begin
      case (ctrl.function_select)
        CLCC_FN_SR: begin
          if (gate_out[0] | gate_out[1]) begin
            seq_q <= 1'b1;
          end else if (gate_out[2] | gate_out[3]) begin
            seq_q <= 1'b0;
          end
        end
        CLCC_FN_DFF_SR: begin
          if (gate_out[2]) begin
            seq_q <= 1'b0;
          end else if (gate_out[3]) begin
            seq_q <= 1'b1;
          end else if (gate_out[0] && !gate0_prev) begin
            seq_q <= gate_out[1];
          end
        end
        CLCC_FN_DFF2_R: begin
          if (gate_out[2]) begin
            seq_q <= 1'b0;
          end else if (gate_out[0] && !gate0_prev) begin
            seq_q <= gate_out[1] & gate_out[3];
          end
        end
        CLCC_FN_JK_R: begin
          if (gate_out[2]) begin
            seq_q <= 1'b0;
          end else if (gate_out[0] && !gate0_prev) begin
            case ({gate_out[1], gate_out[3]})
              2'b10:   seq_q <= 1'b1;
              2'b01:   seq_q <= 1'b0;
              2'b11:   seq_q <= ~seq_q;
              default: seq_q <= seq_q;
            endcase
          end
        end
        CLCC_FN_LATCH: begin
          if (gate_out[0]) begin
            seq_q <= 1'b0;
          end else if (gate_out[3]) begin
            seq_q <= 1'b1;
          end else if (!gate_out[2]) begin
            seq_q <= gate_out[1];
          end
        end
        default: seq_q <= seq_q;
      endcase
    end
  end

  // Function result: combinational codes act on the gates, the others show the stored bit.
  always_comb begin
    case (ctrl.function_select)
      CLCC_FN_AND_OR: func_result = (gate_out[0] & gate_out[1]) |
                                    (gate_out[2] & gate_out[3]);
      CLCC_FN_OR_XOR: func_result = (gate_out[0] | gate_out[1]) ^
                                    (gate_out[2] | gate_out[3]);
      CLCC_FN_AND4:   func_result = &gate_out;
      default:        func_result = seq_q;
    endcase
  end

  // Registered cell output after final inversion, forced low while disabled.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cell_output <= 1'b0;
    end else if (!ctrl.cell_enable) begin
      cell_output <= 1'b0;
    end else begin
      cell_output <= func_result ^ final_invert;
    end
  end

  // Previous output level for edge detection.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cell_output_prev <= 1'b0;
    end else begin
      cell_output_prev <= cell_output;
    end
  end

  // Edge events, including edges caused by flipping the output inversion.
  assign out_rise  = cell_output & ~cell_output_prev;
  assign out_fall  = ~cell_output & cell_output_prev;
  assign irq_event = (out_rise & ctrl.rise_irq_enable) |
                     (out_fall & ctrl.fall_irq_enable);

  // Sticky interrupt flag, cleared by writing one; a new edge wins over the clear.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cell_irq_flag <= 1'b0;
    end else if (irq_event) begin
      cell_irq_flag <= 1'b1;
    end else if (wr_en && wb_adr_i == CLCC_OFF_IRQ_STAT &&
                 wb_dat_i[CLCC_BIT_IRQ_CELL]) begin
      cell_irq_flag <= 1'b0;
    end
  end

  // Interrupt mask register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask <= CLCC_RST_MASK;
    end else if (wr_en && wb_adr_i == CLCC_OFF_IRQ_MASK) begin
      irq_mask <= wb_dat_i[CLCC_BIT_IRQ_CELL];
    end
  end

  // Read data selection; unused bits and unmapped addresses read zero.
  always_comb begin
    next_rdata = 8'h00;
    case (wb_adr_i)
      CLCC_OFF_CONTROL:  next_rdata = {ctrl.cell_enable, 1'b0, cell_output,
                                       ctrl.rise_irq_enable, ctrl.fall_irq_enable,
                                       ctrl.function_select};
      CLCC_OFF_POLARITY: next_rdata = {final_invert, 3'h0, gate_invert};
      CLCC_OFF_SRC_0:    next_rdata = {2'h0, input_source[0]};
      CLCC_OFF_SRC_1:    next_rdata = {2'h0, input_source[1]};
      CLCC_OFF_SRC_2:    next_rdata = {2'h0, input_source[2]};
      CLCC_OFF_SRC_3:    next_rdata = {2'h0, input_source[3]};
      CLCC_OFF_GATE_0:   next_rdata = gate_select[0];
      CLCC_OFF_GATE_1:   next_rdata = gate_select[1];
      CLCC_OFF_GATE_2:   next_rdata = gate_select[2];
      CLCC_OFF_GATE_3:   next_rdata = gate_select[3];
      CLCC_OFF_IRQ_STAT: next_rdata = {7'h00, cell_irq_flag};
      CLCC_OFF_IRQ_MASK: next_rdata = {7'h00, irq_mask};
      default:           next_rdata = 8'h00;
    endcase
  end

  // Bus answer: ack one cycle after the request, dropped the following cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= rd_en;
      if (rd_en && !wb_we_i) begin
        wb_dat_o <= {24'h000000, next_rdata};
      end
    end
  end

  // Outputs.
  assign cell_output_o = cell_output;
  assign irq_o         = cell_irq_flag & irq_mask;

endmodule // clcc_cell

// ---- tb/clcc_cell_monitor.sv ----
// Checker for bus timing, read values, cell output and interrupt of the logic cell.
`timescale 1ns/100ps
module clcc_cell_monitor #(
  parameter int NUM_SRC = 64
) (
  // Clock and reset.
  input wire logic                              clk_i,
  input wire logic                              rst_i,
  // Wishbone classic slave.
  input wire logic                              wb_cyc_i,
  input wire logic                              wb_stb_i,
  input wire logic                              wb_we_i,
  input wire logic [clcc_pkg::CLCC_ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0]                        wb_sel_i,
  input wire logic [clcc_pkg::CLCC_DATA_W-1:0] wb_dat_i,
  input wire logic [clcc_pkg::CLCC_DATA_W-1:0] wb_dat_o,
  input wire logic                              wb_ack_o,
  // Sources and results.
  input wire logic [NUM_SRC-1:0]                src_i,
  input wire logic                              cell_output_o,
  input wire logic                              irq_o
);
  import clcc_pkg::*;
  // Read and write requests taken at this edge.
  logic rd_req;
  logic wr_req;
  assign rd_req = wb_cyc_i & wb_stb_i & !wb_ack_o & !wb_we_i;
  assign wr_req = wb_cyc_i & wb_stb_i & !wb_ack_o & wb_we_i & wb_sel_i[0];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("Ack stood longer than one cycle.");
  a_ack_next_cycle: assert property ((rd_req | wr_req) |=> wb_ack_o)
    else $error("Ack missing one cycle after a request.");
  a_ack_has_req: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i & wb_stb_i))
    else $error("Ack without a request.");
  a_dat_high_zero: assert property (wb_dat_o[31:8] == 24'h0)
    else $error("Upper read data bits not zero.");
  a_ctrl_read_val: assert property (rd_req && wb_adr_i == CLCC_OFF_CONTROL
    |=> !wb_dat_o[6] && wb_dat_o[5] == $past(cell_output_o))
    else $error("Control read does not show the cell output.");
  a_pol_unused_zero: assert property (rd_req && wb_adr_i == CLCC_OFF_POLARITY |=>
    wb_dat_o[6:4] == 3'h0)
    else $error("Unused polarity bits not zero.");
  a_src_unused_zero: assert property (rd_req && wb_adr_i inside {[8'h08:8'h14]} |=>
    wb_dat_o[7:6] == 2'h0)
    else $error("Unused source select bits not zero.");
  a_unmapped_zero: assert property (rd_req && wb_adr_i > 8'h2c |=> wb_dat_o == 32'h0)
    else $error("Unmapped read not zero.");
  a_disable_zero: assert property (wr_req && wb_adr_i == CLCC_OFF_CONTROL
    && !wb_dat_i[7] |-> ##2 !cell_output_o)
    else $error("Disabled cell output not zero.");
  a_irq_has_cause: assert property ($rose(irq_o) |->
    $past(cell_output_o) != $past(cell_output_o, 2)
    || $past(wr_req && wb_adr_i == CLCC_OFF_IRQ_MASK))
    else $error("Interrupt rose without an output edge or mask write.");
endmodule // clcc_cell_monitor

// ---- tb/clcc_cell_tb_top.sv ----
// Self-checking bench for the configurable logic cell.
`timescale 1ns/100ps
module clcc_cell_tb_top;
  import clcc_pkg::*;
  // Bench-driven inputs and observed outputs.
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [63:0] src = 64'h0;
  logic [31:0] dat_o;
  logic        ack;
  logic        out;
  logic        irq;
  int          miscompares = 0;
  int          samples_checked = 0;
  localparam logic [7:0] POLS [3] = '{8'h00, 8'h80, 8'h8a};
  // Steps of the stored functions: expected output, function code, source pattern.
  localparam logic [7:0] SEQ [25] = '{8'hb1, 8'hb0, 8'h34, 8'h44, 8'h42, 8'hc3, 8'hc1,
    8'hc8, 8'h45, 8'h54, 8'h5a, 8'hdb, 8'hd2, 8'h53, 8'h64, 8'h62, 8'he3, 8'he8, 8'h69,
    8'hf2, 8'h70, 8'h74, 8'h76, 8'hfc, 8'h7d};

  clcc_cell #(.NUM_SRC(64)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .src_i(src), .cell_output_o(out), .irq_o(irq));

  // Clock of 100 ns period.
  always #50 clk_i = ~clk_i;

  // Compares a seen value with the expected one.
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  // One classic Wishbone cycle, held until ack is sampled.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] q);
    int n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    dat <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) miscompares++;
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 8'h00, q);
    chk("read data", q, {24'h0, e});
  endtask

  // Sets control and sources, lets the path settle, checks pin and status bit.
  task automatic step(input logic [7:0] ctl, input logic [3:0] p, input logic e);
    wr(CLCC_OFF_CONTROL, ctl);
    src <= {60'h0, p};
    repeat (7) @(posedge clk_i);
    chk("cell output", {31'h0, out}, {31'h0, e});
    rd(CLCC_OFF_CONTROL, ctl | {2'h0, e, 5'h0});
  endtask

  function automatic logic fn(input logic [2:0] m, input logic [3:0] g);
    case (m)
      3'h0: return (g[0] & g[1]) | (g[2] & g[3]);
      3'h1: return (g[0] | g[1]) ^ (g[2] | g[3]);
      default: return &g;
    endcase
  endfunction

  task automatic complete_run;
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Watchdog against a hung handshake.
  initial begin
    #1000000;
    miscompares++;
    complete_run;
  end

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(CLCC_OFF_CONTROL, 8'h00);
    wr(8'h30, 8'hff);
    rd(8'h30, 8'h00);
    wr(CLCC_OFF_POLARITY, 8'hff);
    rd(CLCC_OFF_POLARITY, 8'h8f);
    for (int k = 0; k < 4; k++) begin
      wr(CLCC_OFF_SRC_0 + 8'(4 * k), 8'hc0 | 8'(k));
      rd(CLCC_OFF_SRC_0 + 8'(4 * k), 8'(k));
      wr(CLCC_OFF_GATE_0 + 8'(4 * k), 8'h02 << (2 * k));
    end
    $display("test registers done");
    for (int m = 0; m < 3; m++) begin
      for (int i = 0; i < 3; i++) begin
        wr(CLCC_OFF_POLARITY, POLS[i]);
        for (int p = 0; p < 16; p++) begin
          step({5'h10, m[2:0]}, p[3:0],
               fn(m[2:0], p[3:0] ^ POLS[i][3:0]) ^ POLS[i][7]);
        end
      end
    end
    step(8'h00, 4'hf, 1'b0);
    $display("test functions done");
    wr(CLCC_OFF_POLARITY, 8'h00);
    for (int s = 0; s < 25; s++) begin
      step({5'h10, SEQ[s][6:4]}, SEQ[s][3:0], SEQ[s][7]);
    end
    $display("test stored functions done");
    wr(CLCC_OFF_IRQ_MASK, 8'h01);
    step(8'h92, 4'h0, 1'b0);
    wr(CLCC_OFF_IRQ_STAT, 8'h01);
    step(8'h92, 4'hf, 1'b1);
    rd(CLCC_OFF_IRQ_STAT, 8'h01);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(CLCC_OFF_IRQ_STAT, 8'h01);
    step(8'h92, 4'h0, 1'b0);
    rd(CLCC_OFF_IRQ_STAT, 8'h00);
    chk("irq", {31'h0, irq}, 32'h0);
    step(8'h8a, 4'h0, 1'b0);
    wr(CLCC_OFF_POLARITY, 8'h80);
    repeat (4) @(posedge clk_i);
    rd(CLCC_OFF_IRQ_STAT, 8'h00);
    wr(CLCC_OFF_POLARITY, 8'h00);
    repeat (4) @(posedge clk_i);
    rd(CLCC_OFF_IRQ_STAT, 8'h01);
    wr(CLCC_OFF_IRQ_MASK, 8'h00);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(CLCC_OFF_IRQ_MASK, 8'h01);
    chk("irq", {31'h0, irq}, 32'h1);
    $display("test interrupts done");
    // Gate 0 becomes input 3 true OR input 0 inverted; AND-OR with gate 1 shows it.
    wr(CLCC_OFF_GATE_0, 8'h81);
    step(8'h80, 4'h2, 1'b1);
    step(8'h80, 4'h3, 1'b0);
    step(8'h80, 4'hb, 1'b1);
    $display("test gates done");
    wr(CLCC_OFF_POLARITY, 8'h85);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(CLCC_OFF_CONTROL, 8'h00);
    rd(CLCC_OFF_POLARITY, 8'h05);
    rd(CLCC_OFF_SRC_3, 8'h03);
    rd(CLCC_OFF_GATE_0, 8'h81);
    chk("irq", {31'h0, irq}, 32'h0);
    $display("test reset done");
    complete_run;
  end
endmodule // clcc_cell_tb_top

bind clcc_cell clcc_cell_monitor #(.NUM_SRC(NUM_SRC)) mon (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .src_i(src_i), .cell_output_o(cell_output_o), .irq_o(irq_o));
